// *** iprf_pkg.sv ***
package iprf_pkg;
    // ==========================================
    // register map
    localparam logic [3:0] IPRF_ADDR_PRIO = 4'h0;
    localparam int IPRF_ADDR_W = 4;
    localparam int IPRF_DATA_W = 16;
    localparam int IPRF_PRIO_W = 3;
    // ==========================================
    // field positions
    localparam int IPRF_CAN_TX_LSB = 8;
    localparam int IPRF_DMA7_LSB = 4;
    localparam int IPRF_DMA6_LSB = 0;
    // ==========================================
    // codes and reset values
    localparam logic [2:0] IPRF_PRIO_RESET = 3'h4;
    localparam logic [2:0] IPRF_PRIO_OFF = 3'h0;
    localparam logic [15:0] IPRF_IMPL_MASK = 16'h0777;
endpackage

// *** iprf_prio_regs.sv ***
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
// Overview of operation
// (RULE1) each priority field is three bits, codes 1 to 7 giving levels 1 to 7 with 7 most urgent.
// (RULE2) a field holding code 000 disables its source so its request is never forwarded.
// (RULE3) bits 15 to 11, bit 7 and bit 3 read as zero and ignore writes.
// (RULE4) can transmit request priority sits at bits 10:8, dma channel 7 at 6:4, dma channel 6 at 2:0.
// (RULE5) without the can controller the can transmit source stays disabled whatever is written.
// (RULE6) after reset each field holds code 100 and unimplemented bits are zero.
module iprf_prio_regs #(
    parameter bit CAN_PRESENT = 1'b1
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire logic [3:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    input wire logic can_tx_req_in,
    input wire logic dma_ch7_done_req_in,
    input wire logic dma_ch6_done_req_in,
    output logic [2:0] can_tx_request_priority_out,
    output logic [2:0] dma_ch7_done_priority_out,
    output logic [2:0] dma_ch6_done_priority_out,
    output logic [2:0] can_tx_level_out,
    output logic [2:0] dma_ch7_level_out,
    output logic [2:0] dma_ch6_level_out
);
    // ==========================================
    // storage
    logic [15:0] prio_q;
    logic [15:0] prio_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic [2:0] can_field;
    logic [2:0] dma7_field;
    logic [2:0] dma6_field;
    logic [15:0] reset_word;
    logic hit;
    logic wr_take;
    logic rd_take;
    logic [2:0] src_req;
    logic [2:0] src_code [3];
    logic [2:0] src_level [3];

    // ==========================================
    // address decode
    assign hit = (addr_in == iprf_pkg::IPRF_ADDR_PRIO);
    assign wr_take = wr_in && hit;
    assign rd_take = rd_in && hit;

    // ==========================================
    // next values
    assign reset_word = {5'h00, iprf_pkg::IPRF_PRIO_RESET, 1'b0,
                         iprf_pkg::IPRF_PRIO_RESET, 1'b0, iprf_pkg::IPRF_PRIO_RESET}; // RULE6
    // unimplemented bits are dropped on the way in
    assign prio_d = wr_take ? (wdata_in & iprf_pkg::IPRF_IMPL_MASK) : prio_q; // RULE3
    // read data stand one cycle, zero otherwise
    assign rdata_d = rd_take ? (prio_q & iprf_pkg::IPRF_IMPL_MASK) : 16'h0000; // RULE3

    // ==========================================
    // field register
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            prio_q <= reset_word; // RULE6
        end else if (clk_en_in) begin
            prio_q <= prio_d;
        end
    end

    // ==========================================
    // read data register
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            rdata_q <= 16'h0000;
        end else if (clk_en_in) begin
            rdata_q <= rdata_d;
        end
    end

    // ==========================================
    // field decode
    assign can_field = prio_q[iprf_pkg::IPRF_CAN_TX_LSB +: iprf_pkg::IPRF_PRIO_W]; // RULE4
    assign dma7_field = prio_q[iprf_pkg::IPRF_DMA7_LSB +: iprf_pkg::IPRF_PRIO_W]; // RULE4
    assign dma6_field = prio_q[iprf_pkg::IPRF_DMA6_LSB +: iprf_pkg::IPRF_PRIO_W]; // RULE4

    // ==========================================
    // arbiter levels
    // zero when the field is 000 or the source is idle
    function automatic logic [2:0] iprf_level(input logic req, input logic [2:0] code);
        iprf_level = req ? code : iprf_pkg::IPRF_PRIO_OFF; // RULE1 RULE2
    endfunction

    assign src_req = {can_tx_req_in, dma_ch7_done_req_in, dma_ch6_done_req_in};
    assign src_code[2] = can_tx_request_priority_out; // RULE5
    assign src_code[1] = dma7_field;
    assign src_code[0] = dma6_field;

    generate
        for (genvar i = 0; i < 3; i++) begin : g_src
            assign src_level[i] = iprf_level(src_req[i], src_code[i]); // RULE1 RULE2
        end
    endgenerate

    // ==========================================
    // outputs
    assign rdata_out = rdata_q;
    assign can_tx_request_priority_out = CAN_PRESENT ? can_field : iprf_pkg::IPRF_PRIO_OFF; // RULE5
    assign dma_ch7_done_priority_out = dma7_field;
    assign dma_ch6_done_priority_out = dma6_field;
    assign can_tx_level_out = src_level[2]; // RULE5
    assign dma_ch7_level_out = src_level[1];
    assign dma_ch6_level_out = src_level[0];

    // ==========================================
    // reset checks
    reset_value_a: assert property (@(posedge clock_in) // RULE6
        rst_in |=> prio_q == 16'h0444)
        else $error("bad reset value");

    reset_read_a: assert property (@(posedge clock_in) // RULE6
        rst_in |=> rdata_out == 16'h0000)
        else $error("read data not cleared by reset");

    reset_fields_a: assert property (@(posedge clock_in) // RULE6
        rst_in |=> dma_ch7_done_priority_out == 3'h4 && dma_ch6_done_priority_out == 3'h4)
        else $error("field reset value wrong");

    // ==========================================
    // register access checks
    reserved_zero_a: assert property (@(posedge clock_in) disable iff (rst_in) // RULE3
        (rdata_out & ~iprf_pkg::IPRF_IMPL_MASK) == 16'h0000)
        else $error("reserved bits nonzero");

    reserved_store_a: assert property (@(posedge clock_in) disable iff (rst_in) // RULE3
        (prio_q & ~iprf_pkg::IPRF_IMPL_MASK) == 16'h0000)
        else $error("reserved bits stored");

    write_store_a: assert property (@(posedge clock_in) disable iff (rst_in) // RULE4
        (wr_take && clk_en_in) |=> prio_q == ($past(wdata_in) & 16'h0777))
        else $error("write lost");

    unmapped_write_a: assert property (@(posedge clock_in) disable iff (rst_in) // RULE3
        (wr_in && !hit && clk_en_in) |=> $stable(prio_q))
        else $error("unmapped write landed");

    read_back_a: assert property (@(posedge clock_in) disable iff (rst_in) // RULE3
        (rd_take && clk_en_in && !wr_in) |=> rdata_out == $past(prio_q))
        else $error("read mismatch");

    read_idle_a: assert property (@(posedge clock_in) disable iff (rst_in) // RULE3
        (clk_en_in && !rd_take) |=> rdata_out == 16'h0000)
        else $error("read data outstayed its cycle");

    // ==========================================
    // field placement checks
    can_map_a: assert property (@(posedge clock_in) disable iff (rst_in) // RULE4
        (wr_take && clk_en_in && CAN_PRESENT) |=> can_tx_request_priority_out == $past(wdata_in[10:8]))
        else $error("can field misplaced");

    dma7_map_a: assert property (@(posedge clock_in) disable iff (rst_in) // RULE4
        (wr_take && clk_en_in) |=> dma_ch7_done_priority_out == $past(wdata_in[6:4]))
        else $error("dma7 field misplaced");

    dma6_map_a: assert property (@(posedge clock_in) disable iff (rst_in) // RULE4
        (wr_take && clk_en_in) |=> dma_ch6_done_priority_out == $past(wdata_in[2:0]))
        else $error("dma6 field misplaced");

    // ==========================================
    // level checks
    disabled_src_a: assert property (@(posedge clock_in) disable iff (rst_in) // RULE2
        dma6_field == 3'h0 |-> dma_ch6_level_out == 3'h0)
        else $error("disabled source forwarded");

    can_disabled_a: assert property (@(posedge clock_in) disable iff (rst_in) // RULE2
        can_tx_request_priority_out == 3'h0 |-> can_tx_level_out == 3'h0)
        else $error("disabled can source forwarded");

    dma7_disabled_a: assert property (@(posedge clock_in) disable iff (rst_in) // RULE2
        dma7_field == 3'h0 |-> dma_ch7_level_out == 3'h0)
        else $error("disabled dma7 source forwarded");

    level_pass_a: assert property (@(posedge clock_in) disable iff (rst_in) // RULE1
        dma_ch7_done_req_in |-> dma_ch7_level_out == dma7_field)
        else $error("level wrong");

    can_level_a: assert property (@(posedge clock_in) disable iff (rst_in) // RULE1
        can_tx_req_in |-> can_tx_level_out == can_tx_request_priority_out)
        else $error("can level wrong");

    dma6_level_a: assert property (@(posedge clock_in) disable iff (rst_in) // RULE1
        dma_ch6_done_req_in |-> dma_ch6_level_out == dma6_field)
        else $error("dma6 level wrong");

    can_idle_a: assert property (@(posedge clock_in) disable iff (rst_in)
        !can_tx_req_in |-> can_tx_level_out == 3'h0)
        else $error("idle can source forwarded");

    dma6_idle_a: assert property (@(posedge clock_in) disable iff (rst_in)
        !dma_ch6_done_req_in |-> dma_ch6_level_out == 3'h0)
        else $error("idle dma6 source forwarded");

    can_absent_a: assert property (@(posedge clock_in) disable iff (rst_in) // RULE5
        !CAN_PRESENT |-> can_tx_level_out == 3'h0)
        else $error("can source not disabled");

    can_absent_field_a: assert property (@(posedge clock_in) disable iff (rst_in) // RULE5
        !CAN_PRESENT |-> can_tx_request_priority_out == 3'h0)
        else $error("can field not forced off");

    // ==========================================
    // clock enable checks
    freeze_a: assert property (@(posedge clock_in) disable iff (rst_in)
        !clk_en_in |=> $stable(prio_q))
        else $error("state moved while frozen");

    rdata_freeze_a: assert property (@(posedge clock_in) disable iff (rst_in)
        !clk_en_in |=> $stable(rdata_out))
        else $error("read data moved while frozen");

    // ==========================================
    // covers
    write_cov_c: cover property (@(posedge clock_in) wr_take && clk_en_in);
    read_cov_c: cover property (@(posedge clock_in) rd_take && clk_en_in);
    top_level_c: cover property (@(posedge clock_in) can_tx_level_out == 3'h7);
    disabled_cov_c: cover property (@(posedge clock_in) dma_ch6_done_req_in && dma6_field == 3'h0);
    frozen_write_c: cover property (@(posedge clock_in) wr_take && !clk_en_in);
endmodule // iprf_prio_regs

// *** iprf_prio_regs_tb_top.sv ***
`timescale 1ns/1ps
module iprf_prio_regs_tb_top;
    // ==========================================
    // stimulus and observed signals
    logic clock_in = 1'b0, rst_in = 1'b1, clk_en_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
    logic [3:0] addr_in = 4'h0;
    logic [15:0] wdata_in = 16'h0000, rdata_out;
    logic [2:0] req = 3'h7, pc, p7, p6, lc, l7, l6, nc, nl;
    int n_mismatch = 0, num_checks = 0;
    always #5 clock_in = ~clock_in;
    iprf_prio_regs iprf_prio_regs_inst (.clock_in(clock_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .can_tx_req_in(req[2]), .dma_ch7_done_req_in(req[1]), .dma_ch6_done_req_in(req[0]),
        .can_tx_request_priority_out(pc), .dma_ch7_done_priority_out(p7), .dma_ch6_done_priority_out(p6),
        .can_tx_level_out(lc), .dma_ch7_level_out(l7), .dma_ch6_level_out(l6));
    // second copy without the can controller
    iprf_prio_regs #(.CAN_PRESENT(1'b0)) nocan (.clock_in(clock_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(),
        .can_tx_req_in(req[2]), .dma_ch7_done_req_in(req[1]), .dma_ch6_done_req_in(req[0]),
        .can_tx_request_priority_out(nc), .dma_ch7_done_priority_out(), .dma_ch6_done_priority_out(),
        .can_tx_level_out(nl), .dma_ch7_level_out(), .dma_ch6_level_out());
    // ==========================================
    // tasks
    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task fld(input logic [15:0] f, input logic [15:0] l);
        chk("fields", {5'h00, pc, 1'b0, p7, 1'b0, p6}, f);
        chk("levels", {5'h00, lc, 1'b0, l7, 1'b0, l6}, l);
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock_in) {addr_in, wdata_in, wr_in} <= {a, d, 1'b1};
        @(posedge clock_in) wr_in <= 1'b0;
        #1;
    endtask
    task rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clock_in) {addr_in, rd_in} <= {a, 1'b1};
        @(posedge clock_in) rd_in <= 1'b0;
        #1 chk("rdata", rdata_out, e);
    endtask
    // ==========================================
    // tests
    initial begin
        repeat (500) @(posedge clock_in);
        n_mismatch++;
        report_and_stop;
    end
    initial begin
        repeat (4) @(posedge clock_in);
        rst_in <= 1'b0;
        #1 fld(16'h0444, 16'h0444);
        rd(4'h0, 16'h0444);
        wr(4'h0, 16'hFFFF);
        fld(16'h0777, 16'h0777);
        chk("nocan", {10'h000, nc, nl}, 16'h0000);
        rd(4'h0, 16'h0777);
        wr(4'h0, 16'h0531);
        fld(16'h0531, 16'h0531);
        rd(4'h5, 16'h0000);
        wr(4'h5, 16'h0000);
        rd(4'h0, 16'h0531);
        @(posedge clock_in) #1 chk("rdata idle", rdata_out, 16'h0000);
        @(posedge clock_in) req <= 3'h2;
        #1 fld(16'h0531, 16'h0030);
        @(posedge clock_in) req <= 3'h7;
        wr(4'h0, 16'h0000);
        fld(16'h0000, 16'h0000);
        wr(4'h0, 16'h0652);
        @(posedge clock_in) clk_en_in <= 1'b0;
        wr(4'h0, 16'h0123);
        rd(4'h0, 16'h0000);
        fld(16'h0652, 16'h0652);
        @(posedge clock_in) clk_en_in <= 1'b1;
        rd(4'h0, 16'h0652);
        @(posedge clock_in) rst_in <= 1'b1;
        @(posedge clock_in) rst_in <= 1'b0;
        #1 fld(16'h0444, 16'h0444);
        rd(4'h0, 16'h0444);
        report_and_stop;
    end
endmodule // iprf_prio_regs_tb_top
